// [rtl/input_monitor_defs.svh]
`ifndef INPUT_MONITOR_DEFS_SVH
`define INPUT_MONITOR_DEFS_SVH

// Register offsets on the configuration port.
`define OFS_ABSENT_HI 8'h8A
`define OFS_MON_EN 8'h8B
`define OFS_PHASE1 8'h8E
`define OFS_PHASE2 8'h8F

// Reset values.
`define RST_ABSENT_HI 8'h0F
`define RST_MON_EN 8'hFF
`define RST_PHASE 8'h00

// Writable bits; the rest keep their reset value.
`define WMASK_ABSENT_HI 8'h03
`define WMASK_MON_EN 8'h33

// Field positions.
`define BIT_IN1_FREQ_OFFSET_EN 0
`define BIT_IN2_FREQ_OFFSET_EN 1
`define BIT_ABS1_LO 4
`define BIT_ABS2_LO 5
`define BIT_ABS1_HI 0
`define BIT_ABS2_HI 1

// Timing of the monitors.
`define CLK_PERIOD_NS 100
`define FULL_ABSENT_NS 3200
`define SLOW_ABSENT_NS 12800
`define FULL_ABSENT_CYC ((`FULL_ABSENT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_ABSENT_CYC ((`SLOW_ABSENT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FREQ_WINDOW_END 8'hFF
`define FREQ_EXPECT_EDGES 8'h20
`define FREQ_TOLERANCE 8'h04

`endif

// [rtl/input_monitor_pkg.sv]
package input_monitor_pkg;

   typedef enum logic [1:0] {
      ABS_OFF = 2'b00,
      ABS_RSVD = 2'b01,
      ABS_SLOW = 2'b10,
      ABS_FULL = 2'b11
   } absent_mode_t;

   typedef struct packed {
      logic absent;
      logic freq_off;
   } alarm_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic irq_pin_sel;
      logic irq_polarity;
      logic in1_fault_pin_en;
      logic in2_fault_pin_en;
      logic fault_polarity;
      logic fault_incl_freq;
      logic [3:0] irq_unmask;
   } pin_cfg_t;

endpackage

// [rtl/input_clock_check.sv]
`timescale 1ns/1ps
`default_nettype none
`include "input_monitor_defs.svh"

module input_clock_check
   import input_monitor_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hw_clr,
   // Monitored input and its settings
   input wire logic clock_input,
   input wire input_monitor_pkg::absent_mode_t absent_sel,
   input wire logic freq_en,
   // Status
   output input_monitor_pkg::alarm_t alarm
);

   logic prev_ff;
   logic [7:0] gap_ff;
   logic [7:0] win_ff;
   logic [7:0] edges_ff;
   logic absent_ff;
   logic freq_ff;

   wire logic edge_seen = clock_input & ~prev_ff;
   wire logic gap_sat = (gap_ff == 8'hFF);
   wire logic [7:0] nxt_gap = edge_seen ? 8'h00 : (gap_sat ? gap_ff : gap_ff + 8'h01);
   wire logic win_end = (win_ff == `FREQ_WINDOW_END);
   wire logic [7:0] edges_now = edges_ff + {7'h00, edge_seen};
   wire logic freq_bad = (edges_now < `FREQ_EXPECT_EDGES - `FREQ_TOLERANCE) ||
                         (edges_now > `FREQ_EXPECT_EDGES + `FREQ_TOLERANCE);
   logic nxt_absent;

   // The slow check waits four times longer, so short dropouts pass unreported.
   always_comb
   begin
      unique case (absent_sel)
         ABS_OFF: nxt_absent = 1'b0;
         ABS_RSVD: nxt_absent = 1'b0;
         ABS_SLOW: nxt_absent = nxt_gap >= 8'(`SLOW_ABSENT_CYC);
         ABS_FULL: nxt_absent = nxt_gap >= 8'(`FULL_ABSENT_CYC);
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         prev_ff <= 1'b0;
         gap_ff <= 8'h00;
         win_ff <= 8'h00;
         edges_ff <= 8'h00;
         absent_ff <= 1'b0;
         freq_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= clock_input;
         gap_ff <= hw_clr ? 8'h00 : nxt_gap;
         absent_ff <= ~hw_clr & nxt_absent;
         win_ff <= (hw_clr | ~freq_en) ? 8'h00 : win_ff + 8'h01;
         edges_ff <= (hw_clr | ~freq_en | win_end) ? 8'h00 : edges_now;
         if (hw_clr | ~freq_en)
            freq_ff <= 1'b0;
         else if (win_end)
            freq_ff <= freq_bad;
      end
   end

   assign alarm.absent = absent_ff;
   assign alarm.freq_off = freq_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // A switch into the slow check may meet a flag that the full check set, so only an
   // alarm raised under the slow check is held to the longer threshold.
   slow_threshold_a: assert property (($past(absent_sel) == ABS_SLOW && $rose(absent_ff))
      |-> gap_ff >= 8'(`SLOW_ABSENT_CYC))
      else $error("slow check alarmed before its threshold");

endmodule
`default_nettype wire

// [rtl/input_monitor_alarm_skew_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "input_monitor_defs.svh"

module input_monitor_alarm_skew_ctrl
   import input_monitor_pkg::*;
(
   // Clock and resets
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic rst_hw_n,
   // Register access from the serial port decoder
   input wire input_monitor_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // Pin function settings
   input wire input_monitor_pkg::pin_cfg_t pin_cfg,
   // Monitored clock inputs
   input wire logic clock_input_1,
   input wire logic clock_input_2,
   // Phase offsets to the output dividers
   output logic [7:0] out1_phase_offset,
   output logic [7:0] out2_phase_offset,
   // Clock output enable
   output logic clk_out_oe_n,
   // Alarm pins
   output logic irq_or_in1_fault_pin_o,
   output logic irq_or_in1_fault_pin_oe_n,
   output logic in2_fault_pin_o,
   output logic in2_fault_pin_oe_n,
   // Monitor status, input 2 in the upper pair
   output logic [3:0] alarm_status
);

   ////////////////////////////////////////////////////////////////////////////

   logic [7:0] absent_hi_ff;
   logic [7:0] mon_en_ff;
   logic [7:0] phase1_ff;
   logic [7:0] phase2_ff;
   logic [7:0] rdata_ff;
   logic programmed_ff;
   logic clk_oe_n_ff;
   logic pin1_o_ff;
   logic pin1_oe_n_ff;
   logic pin2_o_ff;
   logic pin2_oe_n_ff;
   alarm_t alarm [2];

   // The hardware reset pin is sampled; it clears state on the clock so that the
   // asynchronous reset stays a constant-only path.
   wire logic hw_clr = ~rst_hw_n;

   wire logic hit_abs_hi = reg_req.addr == `OFS_ABSENT_HI;
   wire logic hit_mon_en = reg_req.addr == `OFS_MON_EN;
   wire logic hit_ph1 = reg_req.addr == `OFS_PHASE1;
   wire logic hit_ph2 = reg_req.addr == `OFS_PHASE2;
   wire logic wr_abs_hi = reg_req.wr & hit_abs_hi;
   wire logic wr_mon_en = reg_req.wr & hit_mon_en;
   wire logic wr_ph1 = reg_req.wr & hit_ph1;
   wire logic wr_ph2 = reg_req.wr & hit_ph2;

   ////////////////////////////////////////////////////////////////////////////

   // Only the writable bits take the written value; reserved bits hold reset.
   wire logic [7:0] abs_hi_wr = (reg_req.wdata & `WMASK_ABSENT_HI) |
                                (`RST_ABSENT_HI & ~`WMASK_ABSENT_HI);
   wire logic [7:0] mon_en_wr = (reg_req.wdata & `WMASK_MON_EN) |
                                (`RST_MON_EN & ~`WMASK_MON_EN);

   wire logic [7:0] nxt_absent_hi = hw_clr ? `RST_ABSENT_HI :
                                    (wr_abs_hi ? abs_hi_wr : absent_hi_ff);
   wire logic [7:0] nxt_mon_en = hw_clr ? `RST_MON_EN :
                                 (wr_mon_en ? mon_en_wr : mon_en_ff);
   wire logic [7:0] nxt_phase1 = hw_clr ? `RST_PHASE :
                                 (wr_ph1 ? reg_req.wdata : phase1_ff);
   wire logic [7:0] nxt_phase2 = hw_clr ? `RST_PHASE :
                                 (wr_ph2 ? reg_req.wdata : phase2_ff);

   // Unmapped reads answer zero.
   wire logic [7:0] rd_mux = hit_abs_hi ? absent_hi_ff :
                             hit_mon_en ? mon_en_ff :
                             hit_ph1 ? phase1_ff :
                             hit_ph2 ? phase2_ff : 8'h00;
   wire logic [7:0] nxt_rdata = reg_req.rd ? rd_mux : rdata_ff;

   // Any register write counts as programming; the clock outputs stay off until then.
   wire logic any_wr = wr_abs_hi | wr_mon_en | wr_ph1 | wr_ph2;
   wire logic nxt_programmed = ~hw_clr & (programmed_ff | any_wr);
   wire logic nxt_clk_oe_n = hw_clr | ~programmed_ff;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         absent_hi_ff <= `RST_ABSENT_HI;
         mon_en_ff <= `RST_MON_EN;
         phase1_ff <= `RST_PHASE;
         phase2_ff <= `RST_PHASE;
         rdata_ff <= 8'h00;
         programmed_ff <= 1'b0;
         clk_oe_n_ff <= 1'b1;
      end
      else
      begin
         absent_hi_ff <= nxt_absent_hi;
         mon_en_ff <= nxt_mon_en;
         phase1_ff <= nxt_phase1;
         phase2_ff <= nxt_phase2;
         rdata_ff <= nxt_rdata;
         programmed_ff <= nxt_programmed;
         clk_oe_n_ff <= nxt_clk_oe_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   wire logic [1:0] clk_in_vec = {clock_input_2, clock_input_1};
   wire logic [1:0] sel_in2 = {absent_hi_ff[`BIT_ABS2_HI], mon_en_ff[`BIT_ABS2_LO]};
   wire logic [1:0] sel_in1 = {absent_hi_ff[`BIT_ABS1_HI], mon_en_ff[`BIT_ABS1_LO]};
   wire logic [3:0] sel_vec = {sel_in2, sel_in1};
   wire logic [1:0] freq_en_vec = {mon_en_ff[`BIT_IN2_FREQ_OFFSET_EN], mon_en_ff[`BIT_IN1_FREQ_OFFSET_EN]};
   logic [3:0] status_vec;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_mon
         input_clock_check u_check (
            .clk_sys(clk_sys),
            .rst(rst),
            .hw_clr(hw_clr),
            .clock_input(clk_in_vec[gi]),
            .absent_sel(absent_mode_t'(sel_vec[2*gi +: 2])),
            .freq_en(freq_en_vec[gi]),
            .alarm(alarm[gi])
         );
         assign status_vec[2*gi +: 2] = {alarm[gi].freq_off, alarm[gi].absent};
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////

   // Interrupt sources are the four monitor flags, each gated by its unmask bit.
   wire logic irq_any = |(status_vec & pin_cfg.irq_unmask);
   wire logic in1_fault = alarm[0].absent | (pin_cfg.fault_incl_freq & alarm[0].freq_off);
   wire logic in2_fault = alarm[1].absent | (pin_cfg.fault_incl_freq & alarm[1].freq_off);
   wire logic irq_level = pin_cfg.irq_polarity ? irq_any : ~irq_any;
   wire logic fault1_level = pin_cfg.fault_polarity ? in1_fault : ~in1_fault;
   wire logic fault2_level = pin_cfg.fault_polarity ? in2_fault : ~in2_fault;
   wire logic pin1_fault_mode = ~pin_cfg.irq_pin_sel & pin_cfg.in1_fault_pin_en;
   wire logic pin1_drive = pin_cfg.irq_pin_sel | pin1_fault_mode;

   wire logic nxt_pin1_o = pin_cfg.irq_pin_sel ? irq_level :
                           (pin1_fault_mode ? fault1_level : 1'b0);
   wire logic nxt_pin1_oe_n = ~pin1_drive;
   wire logic nxt_pin2_o = pin_cfg.in2_fault_pin_en & fault2_level;
   wire logic nxt_pin2_oe_n = ~pin_cfg.in2_fault_pin_en;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pin1_o_ff <= 1'b0;
         pin1_oe_n_ff <= 1'b1;
         pin2_o_ff <= 1'b0;
         pin2_oe_n_ff <= 1'b1;
      end
      else
      begin
         pin1_o_ff <= nxt_pin1_o;
         pin1_oe_n_ff <= nxt_pin1_oe_n;
         pin2_o_ff <= nxt_pin2_o;
         pin2_oe_n_ff <= nxt_pin2_oe_n;
      end
   end

   assign reg_rdata = rdata_ff;
   assign out1_phase_offset = phase1_ff;
   assign out2_phase_offset = phase2_ff;
   assign clk_out_oe_n = clk_oe_n_ff;
   assign irq_or_in1_fault_pin_o = pin1_o_ff;
   assign irq_or_in1_fault_pin_oe_n = pin1_oe_n_ff;
   assign in2_fault_pin_o = pin2_o_ff;
   assign in2_fault_pin_oe_n = pin2_oe_n_ff;
   assign alarm_status = status_vec;

   ////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   mon_en_reset_a: assert property (hw_clr |=> mon_en_ff == 8'hFF && absent_hi_ff == 8'h0F)
      else $error("monitor registers not at default after hardware reset");

   phase_reset_a: assert property (hw_clr |=> out1_phase_offset == 8'h00
      && out2_phase_offset == 8'h00)
      else $error("phase offsets not cleared by hardware reset");

   phase_write_a: assert property (wr_ph2 && !hw_clr |=> out2_phase_offset == $past(reg_req.wdata))
      else $error("phase offset write not taken");

   reserved_read_a: assert property (reg_req.rd && hit_mon_en && !reg_req.wr
      |=> reg_rdata[7:6] == 2'b11 && reg_rdata[3:2] == 2'b11)
      else $error("reserved bits read wrong");

   clk_out_hiz_a: assert property (hw_clr |=> clk_out_oe_n [*2])
      else $error("clock outputs driven during reset");

   unprog_off_a: assert property (!programmed_ff |=> clk_out_oe_n)
      else $error("clock outputs driven before programming");

   irq_level_a: assert property (pin_cfg.irq_pin_sel |=> !irq_or_in1_fault_pin_oe_n
      && irq_or_in1_fault_pin_o == ($past(pin_cfg.irq_polarity) ? $past(irq_any)
      : !$past(irq_any)))
      else $error("interrupt pin level wrong");

   irq_masked_a: assert property (pin_cfg.irq_pin_sel && pin_cfg.irq_polarity
      && pin_cfg.irq_unmask == 4'h0 |=> !irq_or_in1_fault_pin_o)
      else $error("masked source reached interrupt pin");

   fault1_level_a: assert property (pin1_fault_mode && pin_cfg.fault_polarity
      |=> irq_or_in1_fault_pin_o == $past(in1_fault))
      else $error("input-1 fault pin level wrong");

   pin1_hiz_a: assert property (!pin_cfg.irq_pin_sel && !pin_cfg.in1_fault_pin_en
      |=> irq_or_in1_fault_pin_oe_n)
      else $error("shared pin driven with no function");

   pin2_fault_a: assert property (pin_cfg.in2_fault_pin_en |=> !in2_fault_pin_oe_n
      && in2_fault_pin_o == ($past(pin_cfg.fault_polarity) ? $past(in2_fault)
      : !$past(in2_fault)))
      else $error("input-2 fault pin wrong");

   freq_off_a: assert property (!freq_en_vec[0] ##1 !freq_en_vec[0] |-> !alarm[0].freq_off)
      else $error("frequency alarm while monitor disabled");

   absent_off_a: assert property (sel_in2 == 2'b00 |=> !alarm[1].absent)
      else $error("absence alarm while monitor off");

   pin_follow_a: assert property (pin_cfg.in2_fault_pin_en && $stable(pin_cfg)
      && $changed(in2_fault) |=> $changed(in2_fault_pin_o))
      else $error("input-2 fault pin lagged its monitor");

   // Register reads and writes, checked field by field against the map.
   read_data_a: assert property (reg_req.rd && hit_ph1
      |=> reg_rdata == $past(phase1_ff))
      else $error("phase offset read back wrong");

   abs_hi_write_a: assert property (wr_abs_hi && !hw_clr
      |=> absent_hi_ff[7:2] == 6'b000011
      && absent_hi_ff[1:0] == $past(reg_req.wdata[1:0]))
      else $error("upper absence select register written wrong");

   mon_en_write_a: assert property (wr_mon_en && !hw_clr
      |=> mon_en_ff[7:6] == 2'b11 && mon_en_ff[5:4] == $past(reg_req.wdata[5:4])
      && mon_en_ff[1:0] == $past(reg_req.wdata[1:0]))
      else $error("monitor enable register written wrong");

   clk_out_on_a: assert property (programmed_ff && !hw_clr |=> !clk_out_oe_n)
      else $error("clock outputs stayed off after programming");

   pin2_hiz_a: assert property (!pin_cfg.in2_fault_pin_en
      |=> in2_fault_pin_oe_n && !in2_fault_pin_o)
      else $error("input-2 fault pin driven while disabled");

   // The reserved code must behave as off, so a stray write cannot raise alarms.
   absent_rsvd_a: assert property (sel_in1 == 2'b01 |=> !alarm[0].absent)
      else $error("absence alarm under reserved code");

   freq2_off_a: assert property (!freq_en_vec[1] ##1 !freq_en_vec[1]
      |-> !alarm[1].freq_off)
      else $error("input-2 frequency alarm while monitor disabled");

   irq_fired_c: cover property (pin_cfg.irq_pin_sel && $rose(irq_any));
   in1_lost_c: cover property ($rose(alarm[0].absent) && pin1_fault_mode);
   in2_freq_c: cover property ($rose(alarm[1].freq_off));
   programmed_c: cover property ($fell(clk_out_oe_n));
   slow_alarm_c: cover property (sel_in2 == 2'b10 && $rose(alarm[1].absent));

endmodule
`default_nettype wire

// [test/host_port_model.sv]
`timescale 1ns/1ps
`default_nettype none

module host_port_model
(
   // Clock
   input wire logic clk_sys,
   // Register port
   output input_monitor_pkg::reg_req_t reg_req,
   input wire logic [7:0] reg_rdata
);
   import input_monitor_pkg::*;

   initial reg_req = '0;

   ////////////////////////////////////////////////////////////////////////////
   // The idle port shows inverted address and data so a stale value never looks valid.
   task automatic wait_ready(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      #1;
      d = reg_rdata;
   endtask
endmodule

`default_nettype wire

// [test/tb_input_monitor_alarm_skew_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "input_monitor_defs.svh"

module tb_input_monitor_alarm_skew_ctrl;
   import input_monitor_pkg::*;

   logic clk_sys, rst, rst_hw_n, clock_input_1, clock_input_2;
   reg_req_t reg_req;
   pin_cfg_t pin_cfg;
   logic [7:0] reg_rdata, out1_phase_offset, out2_phase_offset, rd;
   logic clk_out_oe_n, p1_o, p1_oe_n, p2_o, p2_oe_n;
   logic [3:0] alarm_status;
   int n_errors = 0;
   int check_count = 0;
   int half1 = 4;
   int half2 = 4;
   int ph1 = 0;
   int ph2 = 0;

   input_monitor_alarm_skew_ctrl dut (.clk_sys(clk_sys), .rst(rst), .rst_hw_n(rst_hw_n),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .pin_cfg(pin_cfg),
      .clock_input_1(clock_input_1), .clock_input_2(clock_input_2),
      .out1_phase_offset(out1_phase_offset), .out2_phase_offset(out2_phase_offset),
      .clk_out_oe_n(clk_out_oe_n), .irq_or_in1_fault_pin_o(p1_o),
      .irq_or_in1_fault_pin_oe_n(p1_oe_n), .in2_fault_pin_o(p2_o),
      .in2_fault_pin_oe_n(p2_oe_n), .alarm_status(alarm_status));

   host_port_model host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // A half period of 4 gives 32 rising edges per window; 0 freezes the input.
   always @(posedge clk_sys)
   begin
      if (half1 != 0)
      begin
         ph1 <= (ph1 + 1 >= half1) ? 0 : ph1 + 1;
         if (ph1 + 1 >= half1)
            clock_input_1 <= ~clock_input_1;
      end
      if (half2 != 0)
      begin
         ph2 <= (ph2 + 1 >= half2) ? 0 : ph2 + 1;
         if (ph2 + 1 >= half2)
            clock_input_2 <= ~clock_input_2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic t_defaults();
      host.read_reg(`OFS_ABSENT_HI, rd);
      check("absent_hi", rd, `RST_ABSENT_HI);
      host.read_reg(`OFS_MON_EN, rd);
      check("mon_en", rd, `RST_MON_EN);
      host.read_reg(`OFS_PHASE1, rd);
      check("phase1", rd, `RST_PHASE);
      check("out2", out2_phase_offset, `RST_PHASE);
      host.read_reg(8'h8C, rd);
      check("unmapped", rd, 8'h00);
      check("clk_oe_n", {7'h00, clk_out_oe_n}, 8'h01);
   endtask

   task automatic t_write();
      host.write_reg(`OFS_MON_EN, 8'h00);
      host.read_reg(`OFS_MON_EN, rd);
      check("mon_en", rd, 8'hCC);
      host.write_reg(`OFS_ABSENT_HI, 8'h00);
      host.read_reg(`OFS_ABSENT_HI, rd);
      check("absent_hi", rd, 8'h0C);
      host.write_reg(`OFS_PHASE1, 8'h80);
      host.write_reg(`OFS_PHASE2, 8'h7F);
      #1;
      check("out1", out1_phase_offset, 8'h80);
      check("out2", out2_phase_offset, 8'h7F);
      host.read_reg(`OFS_PHASE2, rd);
      check("phase2", rd, 8'h7F);
      check("clk_oe_n", {7'h00, clk_out_oe_n}, 8'h00);
   endtask

   // The last edge may lie up to 8 cycles before the freeze, so the quiet probe stays short.
   task automatic t_absent(input logic [7:0] hi, input logic [7:0] en, input int ch,
      input int quiet, input int late, input logic exp);
      half1 = 4;
      half2 = 4;
      host.write_reg(`OFS_ABSENT_HI, hi);
      host.write_reg(`OFS_MON_EN, en);
      repeat (300) @(posedge clk_sys);
      if (ch == 0)
         half1 = 0;
      else
         half2 = 0;
      repeat (quiet) @(posedge clk_sys);
      check("absent quiet", {7'h00, alarm_status[ch * 2]}, 8'h00);
      repeat (late - quiet) @(posedge clk_sys);
      check("absent late", {7'h00, alarm_status[ch * 2]}, {7'h00, exp});
   endtask

   task automatic t_freq();
      half1 = 0;
      half2 = 2;
      host.write_reg(`OFS_ABSENT_HI, 8'h03);
      host.write_reg(`OFS_MON_EN, 8'hFF);
      repeat (600) @(posedge clk_sys);
      check("status all", {4'h0, alarm_status}, 8'h0B);
      t_pin(pin_cfg_t'{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0}, 4'b1010);
      t_pin(pin_cfg_t'{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0}, 4'b1000);
      host.write_reg(`OFS_MON_EN, 8'hFE);
      repeat (3) @(posedge clk_sys);
      check("status in1", {4'h0, alarm_status}, 8'h09);
      host.write_reg(`OFS_MON_EN, 8'hFC);
      repeat (3) @(posedge clk_sys);
      check("status none", {4'h0, alarm_status}, 8'h01);
      half2 = 4;
   endtask

   task automatic t_pin(input pin_cfg_t c, input logic [3:0] exp);
      @(posedge clk_sys);
      pin_cfg <= c;
      repeat (2) @(posedge clk_sys);
      #1;
      check("pins", {4'h0, p1_o, p1_oe_n, p2_o, p2_oe_n}, {4'h0, exp});
   endtask

   task automatic t_hw_reset();
      host.write_reg(`OFS_PHASE1, 8'h3C);
      @(posedge clk_sys);
      rst_hw_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("clk_oe_n", {7'h00, clk_out_oe_n}, 8'h01);
      check("out1", out1_phase_offset, `RST_PHASE);
      @(posedge clk_sys);
      rst_hw_n <= 1'b1;
      host.read_reg(`OFS_MON_EN, rd);
      check("mon_en", rd, `RST_MON_EN);
      check("clk_oe_n", {7'h00, clk_out_oe_n}, 8'h01);
      host.write_reg(`OFS_PHASE2, 8'h01);
      @(posedge clk_sys);
      #1;
      check("clk_oe_n", {7'h00, clk_out_oe_n}, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      conclude();
   end

   initial
   begin
      rst = 1'b1;
      rst_hw_n = 1'b1;
      pin_cfg = '0;
      clock_input_1 = 1'b0;
      clock_input_2 = 1'b0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      host.wait_ready(2);
      t_defaults();
      t_write();
      t_absent(8'h03, 8'hFF, 0, 20, 40, 1'b1);
      t_absent(8'h03, 8'hEF, 0, 100, 140, 1'b1);
      t_absent(8'h03, 8'hFF, 1, 20, 40, 1'b1);
      t_absent(8'h03, 8'hDF, 1, 100, 140, 1'b1);
      t_absent(8'h01, 8'hDF, 1, 100, 200, 1'b0);
      t_absent(8'h01, 8'hFF, 1, 100, 200, 1'b0);
      t_freq();
      t_pin(pin_cfg_t'{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0}, 4'b1000);
      t_pin(pin_cfg_t'{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0}, 4'b0010);
      t_pin(pin_cfg_t'{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'h1}, 4'b1001);
      t_pin(pin_cfg_t'{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1}, 4'b0001);
      t_pin(pin_cfg_t'{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'hE}, 4'b0001);
      t_pin(pin_cfg_t'{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'hF}, 4'b0101);
      t_hw_reset();
      conclude();
   end
endmodule

`default_nettype wire
